// >>> dual_dac_defs.svh
`ifndef DUAL_DAC_DEFS_SVH
`define DUAL_DAC_DEFS_SVH

// command word layout
`define CMD_BITS      16
`define CMD_SEL_BIT   15
`define CMD_GAIN_BIT  13
`define CMD_ACT_BIT   12
`define CMD_CODE_MSB  11
`define CODE_BITS     12

// shift counter
`define BIT_COUNT_W   5
`define BIT_COUNT_FULL 5'h10
`define BIT_COUNT_ZERO 5'h00
`define BIT_COUNT_ONE  5'h01

// reset values of a channel latch and of the shift and word registers
`define RST_GAIN_N    1'b0
`define RST_ACTIVE    1'b0
`define RST_CODE      12'h000
`define RST_WORD      16'h0000

// buffering
`define FIFO_DEPTH    4

// synchroniser slots
`define SYNC_W        5
`define SYNC_CS       4
`define SYNC_SCK      3
`define SYNC_SDI      2
`define SYNC_LOAD     1
`define SYNC_SHUTDOWN_N     0
`define SYNC_RST      5'h1b

`endif

// >>> dual_dac_pkg.sv
`default_nettype none

package dual_dac_pkg;
  // state of one channel latch
  typedef struct packed {
    logic        gain_select_n;
    logic        active_enable;
    logic [11:0] output_code;
  } channel_cfg_t;

  // serial pins of the host link
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } serial_pins_t;
endpackage

`default_nettype wire

// >>> dual_dac_serial_load.sv
`timescale 1ns/100ps
`default_nettype none
`include "dual_dac_defs.svh"

// =====================================================================
// command buffer
module cmd_fifo #(
  parameter int WIDTH = `CMD_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[PW-1:0]];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (in_valid && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule

// =====================================================================
// serial load logic
module dual_dac_serial_load #(
  parameter bit DUAL       = 1'b1,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire dual_dac_pkg::serial_pins_t  serial_in,
  input  wire logic                        output_load_strobe_n,
  input  wire logic                        shutdown_n,
  output dual_dac_pkg::channel_cfg_t       channel_a,
  output dual_dac_pkg::channel_cfg_t       channel_b
);
  // no serial output exists: the link is write-only

  // =====================================================================
  // pin synchronisers
  logic [`SYNC_W-1:0] sync1;
  logic [`SYNC_W-1:0] sync2;
  logic [`SYNC_W-1:0] sync3;
  logic               cs_s;
  logic               sdi_s;
  logic               load_s;
  logic               hw_off;
  logic               sck_rise;
  logic               cs_rise;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1 <= `SYNC_RST;
      sync2 <= `SYNC_RST;
      sync3 <= `SYNC_RST;
    end else begin
      sync1 <= {serial_in.cs_n, serial_in.sck, serial_in.sdi, output_load_strobe_n, shutdown_n};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign cs_s     = sync2[`SYNC_CS];
  assign sdi_s    = sync2[`SYNC_SDI];
  assign load_s   = sync2[`SYNC_LOAD];
  assign hw_off   = !DUAL && !sync2[`SYNC_SHUTDOWN_N];
  // rising clock edge serves mode 0,0 and mode 1,1 alike
  assign sck_rise = sync2[`SYNC_SCK] && !sync3[`SYNC_SCK];
  assign cs_rise  = cs_s && !sync3[`SYNC_CS];

  // =====================================================================
  // shift register and frame check
  logic [`CMD_BITS-1:0]    shift;
  logic [`BIT_COUNT_W-1:0] count;
  logic [`CMD_BITS-1:0]    word;
  logic                    pending;
  logic [`CMD_BITS-1:0]    next_shift;
  logic [`BIT_COUNT_W-1:0] next_count;
  logic [`CMD_BITS-1:0]    next_word;
  logic                    next_pending;
  logic                    push_ready;

  always_comb begin
    next_shift   = shift;
    next_count   = count;
    next_word    = word;
    next_pending = pending;
    if (cs_s) begin
      next_count = `BIT_COUNT_ZERO;
    end else if (sck_rise && count != `BIT_COUNT_FULL) begin
      next_shift = {shift[`CMD_BITS-2:0], sdi_s};
      next_count = count + `BIT_COUNT_ONE;
    end
    if (pending && push_ready) begin
      next_pending = 1'b0;
    end
    // a frame counts only if select stayed low for all sixteen bits
    if (cs_rise && count == `BIT_COUNT_FULL) begin
      next_word    = shift;
      next_pending = 1'b1;
    end
    // shorter frames fall through without touching word or pending
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      shift   <= `RST_WORD;
      count   <= `BIT_COUNT_ZERO;
      word    <= `RST_WORD;
      pending <= 1'b0;
    end else begin
      shift   <= next_shift;
      count   <= next_count;
      word    <= next_word;
      pending <= next_pending;
    end
  end

  // =====================================================================
  // command buffer between link and latches
  logic                 pop_valid;
  logic                 pop_ready;
  logic [`CMD_BITS-1:0] pop_data;
  logic                 pop;
  logic                 drain_hold;
  logic                 next_drain_hold;

  cmd_fifo #(
    .WIDTH (`CMD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (pending),
    .in_ready  (push_ready),
    .in_data   (word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // latches take at most one command every other cycle
  assign pop_ready = !drain_hold;
  assign pop       = pop_valid && pop_ready;

  always_comb begin
    next_drain_hold = pop;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      drain_hold <= 1'b0;
    end else begin
      drain_hold <= next_drain_hold;
    end
  end

  // =====================================================================
  // input and output latches
  dual_dac_pkg::channel_cfg_t in_a;
  dual_dac_pkg::channel_cfg_t in_b;
  dual_dac_pkg::channel_cfg_t next_in_a;
  dual_dac_pkg::channel_cfg_t next_in_b;
  dual_dac_pkg::channel_cfg_t next_out_a;
  dual_dac_pkg::channel_cfg_t next_out_b;
  dual_dac_pkg::channel_cfg_t cmd_cfg;
  dual_dac_pkg::channel_cfg_t rst_cfg;

  assign rst_cfg = '{`RST_GAIN_N, `RST_ACTIVE, `RST_CODE};

  // field split of the command word
  assign cmd_cfg.gain_select_n = pop_data[`CMD_GAIN_BIT];
  assign cmd_cfg.active_enable = pop_data[`CMD_ACT_BIT];
  assign cmd_cfg.output_code   = pop_data[`CMD_CODE_MSB:0];

  always_comb begin
    next_in_a  = in_a;
    next_in_b  = in_b;
    next_out_a = channel_a;
    next_out_b = channel_b;
    // writes land even while a channel is shut down, except its active bit, which stays cleared
    if (pop) begin
      if (pop_data[`CMD_SEL_BIT]) begin
        if (DUAL) begin
          next_in_b = cmd_cfg;
        end
      end else begin
        next_in_a = cmd_cfg;
      end
    end
    if (!load_s) begin
      next_out_a = in_a;
      next_out_b = in_b;
    end
    if (hw_off) begin
      next_in_a.active_enable  = 1'b0;
      next_out_a.active_enable = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      in_a      <= rst_cfg;
      in_b      <= rst_cfg;
      channel_a <= rst_cfg;
      channel_b <= rst_cfg;
    end else begin
      in_a      <= next_in_a;
      in_b      <= next_in_b;
      channel_a <= next_out_a;
      channel_b <= next_out_b;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_full_frame;
    cs_rise && count == `BIT_COUNT_FULL;
  endsequence

  sequence s_short_frame;
    cs_rise && count != `BIT_COUNT_FULL && !pending;
  endsequence

  sequence s_pop_a;
    pop && !pop_data[`CMD_SEL_BIT];
  endsequence

  a_count_capped: assert property (count <= `BIT_COUNT_FULL)
    else $error("bit count passed sixteen");
  a_idle_no_shift: assert property (cs_s |=> count == `BIT_COUNT_ZERO && $stable(shift))
    else $error("shifted while select high");
  a_full_capture: assert property (s_full_frame |=> pending && word == $past(shift))
    else $error("full frame not captured");
  a_short_dropped: assert property (s_short_frame |=> !pending)
    else $error("partial frame was kept");
  a_load_copy: assert property (!load_s && !hw_off |=> channel_a == $past(in_a) && channel_b == $past(in_b))
    else $error("output latch missed load");
  a_select_b: assert property (DUAL && pop && pop_data[`CMD_SEL_BIT]
      |=> in_b.output_code == $past(pop_data[`CMD_CODE_MSB:0]))
    else $error("channel b write lost");
  a_single_b_idle: assert property (!DUAL |-> in_b == rst_cfg)
    else $error("single part wrote channel b");
  a_gain_field: assert property (pop && !pop_data[`CMD_SEL_BIT] && !hw_off
      |=> in_a.gain_select_n == $past(pop_data[`CMD_GAIN_BIT]) && in_a.active_enable == $past(pop_data[`CMD_ACT_BIT]))
    else $error("channel a fields wrong");
  a_reset_standby: assert property ($past(reset) |-> !channel_a.active_enable && !channel_b.active_enable)
    else $error("channel active after reset");
  a_hw_standby: assert property (hw_off |=> !in_a.active_enable && !channel_a.active_enable)
    else $error("hardware shutdown ignored");
  a_pass_through: assert property (s_pop_a ##1 !load_s
      |=> channel_a.output_code == $past(pop_data[`CMD_CODE_MSB:0], 2))
    else $error("command did not reach output");
endmodule

`default_nettype wire

// >>> spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// serial host: mode 0,0 or 1,1, frames of any clock count
module spi_host_model (
  output var dual_dac_pkg::serial_pins_t pins
);
  initial begin
    pins.cs_n = 1'b1;
    pins.sck  = 1'b1;
    pins.sdi  = 1'b0;
  end

  // mode_11 picks the idle level of the clock; data changes on the fall
  task automatic send(input logic [15:0] word, input int nclk, input logic mode_11);
    int i;
    pins.sck = mode_11;
    #40;
    pins.cs_n = 1'b0;
    #40;
    for (i = 0; i < nclk; i++) begin
      pins.sck = 1'b0;
      pins.sdi = (i < 16) ? word[15 - i] : (~word[0] ^ i[0]);
      #32;
      pins.sck = 1'b1;
      #32;
    end
    if (!mode_11) begin
      pins.sck = 1'b0;
      #32;
    end
    pins.cs_n = 1'b1;
    // released data line shows no stale bit
    pins.sdi = ~pins.sdi;
    #100;
  endtask

  // clock and data wiggle while not selected
  task automatic toggle_idle(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      pins.sck = ~pins.sck;
      pins.sdi = i[1];
      #32;
    end
    pins.sck = 1'b1;
  endtask
endmodule

`default_nettype wire

// >>> dual_dac_serial_load_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dual_dac_serial_load_tb;
  logic                       clock;
  logic                       reset;
  logic                       output_load_strobe_n;
  logic                       shutdown_n;
  dual_dac_pkg::serial_pins_t serial_in;
  dual_dac_pkg::channel_cfg_t channel_a;
  dual_dac_pkg::channel_cfg_t channel_b;
  dual_dac_pkg::channel_cfg_t single_a;
  dual_dac_pkg::channel_cfg_t single_b;
  int                         fail_count;
  int                         comparisons;
  int                         cycles;

  dual_dac_serial_load #(.DUAL(1'b1), .FIFO_DEPTH(4)) dual_dac_serial_load_inst (
    .clock(clock), .reset(reset), .serial_in(serial_in),
    .output_load_strobe_n(output_load_strobe_n), .shutdown_n(shutdown_n),
    .channel_a(channel_a), .channel_b(channel_b));

  dual_dac_serial_load #(.DUAL(1'b0), .FIFO_DEPTH(4)) dual_dac_serial_load_single_inst (
    .clock(clock), .reset(reset), .serial_in(serial_in),
    .output_load_strobe_n(output_load_strobe_n), .shutdown_n(shutdown_n),
    .channel_a(single_a), .channel_b(single_b));

  spi_host_model spi_host_model_inst (.pins(serial_in));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // =====================================================================
  // checking and reporting
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic settle();
    repeat (20) @(posedge clock);
    #1;
  endtask

  task automatic drive(input logic strobe_n, input logic shutdown_n_n);
    @(posedge clock);
    #1;
    output_load_strobe_n = strobe_n;
    shutdown_n = shutdown_n_n;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    reset = 1'b1;
    output_load_strobe_n = 1'b1;
    shutdown_n = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    reset = 1'b0;
    settle();
    check(channel_a, 14'h0000);
    check(channel_b, 14'h0000);
    // both input latches filled, output held until the strobe
    spi_host_model_inst.send(16'h3abc, 16, 1'b0);
    spi_host_model_inst.send(16'hd123, 16, 1'b1);
    settle();
    check(channel_a, 14'h0000);
    check(channel_b, 14'h0000);
    drive(1'b0, 1'b1);
    settle();
    check(channel_a, {1'b1, 1'b1, 12'habc});
    check(channel_b, {1'b0, 1'b1, 12'h123});
    // strobe held low: pass-through, surplus clocks
    spi_host_model_inst.send(16'h2fff, 20, 1'b0);
    settle();
    check(channel_a, {1'b1, 1'b0, 12'hfff});
    spi_host_model_inst.send(16'h1000, 16, 1'b1);
    settle();
    check(channel_a, {1'b0, 1'b1, 12'h000});
    // short frame, then clocks with select high
    spi_host_model_inst.send(16'hbfff, 10, 1'b1);
    settle();
    check(channel_b, {1'b0, 1'b1, 12'h123});
    check(channel_a, {1'b0, 1'b1, 12'h000});
    spi_host_model_inst.toggle_idle(12);
    settle();
    check(channel_a, {1'b0, 1'b1, 12'h000});
    check(channel_b, {1'b0, 1'b1, 12'h123});
    // single-channel variant and its shutdown pin
    check(single_b, 14'h0000);
    check(single_a, {1'b0, 1'b1, 12'h000});
    drive(1'b0, 1'b0);
    settle();
    check(single_a, {1'b0, 1'b0, 12'h000});
    check(channel_a, {1'b0, 1'b1, 12'h000});
    drive(1'b0, 1'b1);
    settle();
    check(single_a, {1'b0, 1'b0, 12'h000});
    spi_host_model_inst.send(16'h1555, 16, 1'b0);
    settle();
    check(single_a, {1'b0, 1'b1, 12'h555});
    check(channel_a, {1'b0, 1'b1, 12'h555});
    print_verdict();
  end
endmodule

`default_nettype wire
